// File: include/crl_pkg.sv
package crl_pkg;
	// Byte addresses on the bus: printed data addresses are not all multiples of four,
	// so each printed address is kept as an index and the byte address is four times it.
	localparam logic [7:0] CRL_IDX_CMP_CTRL = 8'h9c;
	localparam logic [7:0] CRL_IDX_LADDER_CTRL = 8'h9d;
	localparam int CRL_ADDR_W = 12;
	localparam logic [11:0] CRL_ADDR_CMP_CTRL = {2'h0, CRL_IDX_CMP_CTRL, 2'h0};
	localparam logic [11:0] CRL_ADDR_LADDER_CTRL = {2'h0, CRL_IDX_LADDER_CTRL, 2'h0};
	// Reset values
	localparam logic [7:0] CRL_RST_CMP_CTRL = 8'h07;
	localparam logic [7:0] CRL_RST_LADDER_CTRL = 8'h00;
	// Field positions of the reference ladder control register
	localparam int CRL_BIT_POWER_ON = 7;
	localparam int CRL_BIT_PIN_ROUTE = 6;
	localparam int CRL_BIT_RANGE = 5;
	localparam int CRL_BIT_UNUSED = 4;
	localparam logic [7:0] CRL_LADDER_WMASK = 8'hef;
	// Comparator control: mode field in bits 2:0, writable bits 5:0, outputs in 7:6
	localparam logic [7:0] CRL_CMP_WMASK = 8'h3f;
	localparam logic [2:0] CRL_MODE_INT_REF = 3'h6;
	// Tap count of the ladder and width of the tap code
	localparam int CRL_TAPS = 16;
	localparam int CRL_TAP_W = 4;
endpackage : crl_pkg

// File: core/crl_reg8.sv
// Byte register with a write mask; reset clears every bit, and masked-off bits take rstValue on each write
module crl_reg8 (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] rstValue,
	input wire logic [7:0] wrMask,
	input wire logic wrEn,
	input wire logic [7:0] wrData,
	output logic [7:0] q
);
	// Reset clears to zero; the asynchronous branch takes constants only,
	// so the tie-off value is applied to masked bits on each write instead
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			q <= 8'h00;
		end else if (wrEn) begin
			q <= (wrData & wrMask) | (rstValue & ~wrMask);
		end
	end
endmodule : crl_reg8

// File: core/crl_ladder_ctrl.sv
// Notes on behaviour
// - The ladder control register sits at data address 9Dh and resets to 000-0000.
// - Bit 7 powers the ladder on when set and powers it down when clear.
// - Bit 6 connects the generated reference to the shared analog pin when set.
// - Bit 5 picks the range, code/24 of supply when set, supply/4 plus code/32 when clear.
// - Bit 4 is unimplemented, ignores writes and reads as zero.
// - Bits 3:0 are the tap code driving the sixteen-way analog multiplexer select.
// - The ladder output is the comparator reference only when the mode field is 110.
// - In mode 110 the internal reference feeds the non-inverting input of both comparators.
//
// The APB interface to the registers was chosen for this implementation.
module crl_ladder_ctrl #(
	parameter int TAPS = crl_pkg::CRL_TAPS
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [crl_pkg::CRL_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [1:0] comparatorOutputs,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic ladderPowerOn,
	output logic ladderPinRoute,
	output logic ladderRangeSelect,
	output logic [crl_pkg::CRL_TAP_W-1:0] ladderTapCode,
	output logic [15:0] ladderTapSelect,
	output logic internalRefSelect,
	output logic [2:0] comparatorModeField
);
	import crl_pkg::*;

	// The tap decoder and code width are built for exactly sixteen taps
	if (TAPS != 16) begin : gTapCheck
		$error("crl_ladder_ctrl serves only a 16-tap ladder");
	end

	// The tap code must be exactly wide enough to name every tap
	if (CRL_TAP_W != $clog2(TAPS)) begin : gCodeCheck
		$error("crl_ladder_ctrl tap code width does not match the tap count");
	end

	// Bit 4 must stay outside the write mask, or it could be set by software
	if (CRL_LADDER_WMASK[CRL_BIT_UNUSED] != 1'b0) begin : gMaskCheck
		$error("crl_ladder_ctrl write mask covers the unimplemented bit");
	end

	// The two registers must decode to different words
	if (CRL_ADDR_LADDER_CTRL == CRL_ADDR_CMP_CTRL) begin : gAddrCheck
		$error("crl_ladder_ctrl register addresses overlap");
	end

	logic ladderWr;
	logic cmpWr;
	logic hitLadder;
	logic hitCmp;
	logic [7:0] ladderReg;
	logic [7:0] cmpReg;
	logic [31:0] rdNext;

	// Address decode; the register byte lives in lane 0
	assign hitLadder = (paddr == CRL_ADDR_LADDER_CTRL);
	assign hitCmp = (paddr == CRL_ADDR_CMP_CTRL);
	// Writes land only at the edge where ready is sampled high, so a master
	// that aborts before the answer never changes the analog settings
	assign ladderWr = psel && penable && pready && pwrite && hitLadder && pstrb[0];
	assign cmpWr = psel && penable && pready && pwrite && hitCmp && pstrb[0];

	// Reference ladder control: bit 4 is masked so it stays zero
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ladderReg <= CRL_RST_LADDER_CTRL;
		end else if (ladderWr) begin
			ladderReg <= pwdata[7:0] & CRL_LADDER_WMASK;
		end
	end

	// Comparator control: all six writable bits 5:0 are kept here
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cmpReg <= CRL_RST_CMP_CTRL;
		end else if (cmpWr) begin
			cmpReg <= pwdata[7:0] & CRL_CMP_WMASK;
		end
	end

	// Read mux; comparator outputs are live status in bits 7:6
	always_comb begin
		rdNext = 32'h00000000;
		if (hitLadder) begin
			rdNext = {24'h000000, ladderReg & CRL_LADDER_WMASK};
		end else if (hitCmp) begin
			rdNext = {24'h000000, comparatorOutputs, cmpReg[5:0]};
		end
	end

	// Access phase seen at an edge; its first edge opens the single wait state
	logic apbAccess;
	logic apbFirst;
	assign apbAccess = psel && penable;
	assign apbFirst = apbAccess && !pready;

	// Ready pulse: one wait state, so ready rises in the second access cycle.
	// A registered answer keeps the decode off the bus return path.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pready <= 1'b0;
		end else begin
			pready <= apbFirst;
		end
	end

	// Error flag stands with ready; unmapped addresses complete without a write
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= apbFirst && !(hitLadder || hitCmp);
		end
	end

	// Read data stand only with ready and are zero otherwise, so no stale word leaks
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h00000000;
		end else begin
			prdata <= (apbFirst && !pwrite) ? rdNext : 32'h00000000;
		end
	end

	// Ladder power switch, one edge after the register updates
	// A cleared bit opens the switch so the ladder draws no current
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ladderPowerOn <= 1'b0;
		end else begin
			ladderPowerOn <= ladderReg[CRL_BIT_POWER_ON];
		end
	end

	// Pin routing of the generated level to the shared analog pin
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ladderPinRoute <= 1'b0;
		end else begin
			ladderPinRoute <= ladderReg[CRL_BIT_PIN_ROUTE];
		end
	end

	// Range select; the segment scaling itself lives in the analog ladder
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ladderRangeSelect <= 1'b0;
		end else begin
			ladderRangeSelect <= ladderReg[CRL_BIT_RANGE];
		end
	end

	// Binary tap code for the analog multiplexer
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ladderTapCode <= '0;
		end else begin
			ladderTapCode <= ladderReg[CRL_TAP_W-1:0];
		end
	end

	// Comparator mode copy; reset leaves the comparators off
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			comparatorModeField <= CRL_RST_CMP_CTRL[2:0];
		end else begin
			comparatorModeField <= cmpReg[2:0];
		end
	end

	// Both comparators take the ladder on their + input only in this mode
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			internalRefSelect <= 1'b0;
		end else begin
			internalRefSelect <= (cmpReg[2:0] == CRL_MODE_INT_REF);
		end
	end

	// One-hot mux select per tap; range scaling is done by the ladder segments
	genvar t;
	for (t = 0; t < TAPS; t++) begin : gTap
		always_ff @(posedge ref_clk or posedge reset) begin
			if (reset) begin
				ladderTapSelect[t] <= (t == 0); // Tap 0 matches the reset code
			end else begin
				ladderTapSelect[t] <= (ladderReg[CRL_TAP_W-1:0] == CRL_TAP_W'(t));
			end
		end
	end

	// Shadow of the comparator mode bits, kept in the byte register helper.
	// It is not read by the outputs; it holds the last written mode bits, zero after reset, for debug probing.
	logic [7:0] modeShadow;
	crl_reg8 uShadow (
		.ref_clk(ref_clk),
		.reset(reset),
		.rstValue(8'h00),
		.wrMask(8'h07),
		.wrEn(cmpWr),
		.wrData(pwdata[7:0]),
		.q(modeShadow)
	);
	logic unusedShadow;
	assign unusedShadow = ^modeShadow;
endmodule : crl_ladder_ctrl

// File: bench/crl_ladder_ctrl_chk.sv
module crl_ladder_ctrl_chk (
	input wire logic ref_clk, reset, psel, penable, pwrite, pready, pslverr,
	input wire logic [crl_pkg::CRL_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic [3:0] pstrb,
	input wire logic ladderPowerOn, ladderPinRoute, ladderRangeSelect, internalRefSelect,
	input wire logic [3:0] ladderTapCode,
	input wire logic [15:0] ladderTapSelect,
	input wire logic [2:0] comparatorModeField
);
	import crl_pkg::*;
	logic wr;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// Ladder write taken at the edge where ready is sampled high
	assign wr = psel && penable && pready && pwrite && pstrb[0] && paddr == CRL_ADDR_LADDER_CTRL;
	tap_follow_a: assert property (wr |-> ##2 ladderTapCode == $past(pwdata[3:0], 2))
		else $error("tap code late");
	power_follow_a: assert property (wr |-> ##2 ladderPowerOn == $past(pwdata[7], 2))
		else $error("power bit wrong");
	route_follow_a: assert property (wr |-> ##2 ladderPinRoute == $past(pwdata[6], 2))
		else $error("pin route wrong");
	range_follow_a: assert property (wr |-> ##2 ladderRangeSelect == $past(pwdata[5], 2))
		else $error("range bit wrong");
	tap_onehot_a: assert property (ladderTapSelect == 16'h0001 << ladderTapCode)
		else $error("tap select wrong");
	ref_mode_a: assert property (internalRefSelect == (comparatorModeField == 3'h6))
		else $error("reference routing wrong");
	bit_four_a: assert property (pready && !pwrite && paddr == CRL_ADDR_LADDER_CTRL
		|-> prdata[31:8] == 24'h0 && !prdata[4]) else $error("unused bits set");
	map_ok_a: assert property (pready && paddr == CRL_ADDR_LADDER_CTRL |-> !pslverr)
		else $error("ladder address refused");
	cover property (wr);
	cover property (pready && pslverr);
	cover property (internalRefSelect);
endmodule : crl_ladder_ctrl_chk
bind crl_ladder_ctrl crl_ladder_ctrl_chk chk_u (.*);

// File: bench/crl_ladder_model.sv
module crl_ladder_model (
	input wire logic ladderPowerOn, ladderRangeSelect, internalRefSelect,
	input wire logic [3:0] ladderTapCode,
	input wire logic [7:0] vinLevel,
	output logic [1:0] comparatorOutputs
);
	logic [7:0] refLevel;
	// Level in 96ths of supply; a powered-down ladder gives none
	assign refLevel = !ladderPowerOn ? 8'h00 : ladderRangeSelect ? ladderTapCode * 8'h04
		: 8'h18 + ladderTapCode * 8'h03;
	// Both comparators see the ladder only in the internal mode
	assign comparatorOutputs = {2{internalRefSelect && vinLevel > refLevel}};
endmodule : crl_ladder_model

// File: bench/crl_ladder_ctrl_test.sv
module crl_ladder_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	import crl_pkg::*;
	logic ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, er;
	logic pready, pslverr, ladderPowerOn, ladderPinRoute, ladderRangeSelect, internalRefSelect;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hf, ladderTapCode;
	logic [15:0] ladderTapSelect;
	logic [2:0] comparatorModeField;
	logic [1:0] comparatorOutputs;
	int fail_count = 0, n_checks = 0;
	crl_ladder_ctrl dut_u (.*);
	crl_ladder_model model_u (.vinLevel(8'h28), .*);
	initial forever #20 ref_clk = ~ref_clk;
	task automatic finish_test();
		if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [31:0] exp, got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// One transfer; the bound stops a slave that never answers
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge ref_clk);
		{psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
		@(posedge ref_clk);
		penable <= 1'h1;
		do @(posedge ref_clk) n++; while (pready !== 1'h1 && n < 20);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'h0;
		if (n >= 20) begin
			fail_count++;
			finish_test();
		end
	endtask : apb
	task automatic t_reset();
		apb(1'h0, CRL_ADDR_LADDER_CTRL, 32'h0);
		chk("ladder reset", 32'h0, rd);
		apb(1'h0, CRL_ADDR_CMP_CTRL, 32'h0);
		chk("mode reset", 32'h7, rd);
	endtask : t_reset
	task automatic t_fields();
		apb(1'h1, CRL_ADDR_LADDER_CTRL, 32'hff);
		repeat (2) @(posedge ref_clk);
		chk("fields", 32'h7f, {ladderPowerOn, ladderPinRoute, ladderRangeSelect, ladderTapCode});
		chk("tap select", 32'h8000, ladderTapSelect);
		pstrb <= 4'h0;
		apb(1'h1, CRL_ADDR_LADDER_CTRL, 32'h0);
		pstrb <= 4'hf;
		apb(1'h0, CRL_ADDR_LADDER_CTRL, 32'h0);
		chk("read back", 32'hef, rd);
	endtask : t_fields
	task automatic t_mode();
		apb(1'h1, CRL_ADDR_CMP_CTRL, 32'h6);
		apb(1'h1, CRL_ADDR_LADDER_CTRL, 32'ha6);
		apb(1'h0, CRL_ADDR_CMP_CTRL, 32'h0);
		chk("high range", 32'hc6, rd);
		chk("mode out", 32'he, {28'h0, internalRefSelect, comparatorModeField});
		apb(1'h1, CRL_ADDR_LADDER_CTRL, 32'h86);
		apb(1'h0, CRL_ADDR_CMP_CTRL, 32'h0);
		chk("low range", 32'h6, rd);
		apb(1'h0, 12'h000, 32'h0);
		chk("unmapped", 32'h1, {31'h0, er});
	endtask : t_mode
	initial begin
		repeat (6) @(posedge ref_clk);
		reset <= 1'h0;
		t_reset();
		t_fields();
		t_mode();
		finish_test();
	end
endmodule : crl_ladder_ctrl_test
